//--- dv/cuam_bus_model.sv
// Far-side model: frames arriving off the bus into the receive path
`timescale 1ns/1ns
module cuam_bus_model (
    // Clock
    input wire logic clk_i,
    // Receive path
    output cuam_pkg::cuam_rx_t rx_o,
    output cuam_pkg::cuam_filt_t filt_o
);
    initial begin
        rx_o = '0;
        filt_o = '0;
    end
    // ----
    // Reception end, one cycle per frame
    // ----
    task automatic frame_end(input logic [3:0] mb);
        @(posedge clk_i);
        rx_o.done <= 1'b1;
        rx_o.mbox <= mb;
        @(posedge clk_i);
        rx_o.done <= 1'b0;
    endtask
    // Frame identifier against the mailbox 0 entry
    task automatic present(input logic ri, input logic [28:0] rid, input logic fi,
            input logic [28:0] fid);
        @(posedge clk_i);
        rx_o.ide <= ri;
        rx_o.id <= rid;
        filt_o.ide <= fi;
        filt_o.id <= fid;
    endtask
endmodule

//--- dv/cuam_core_tb.sv
// Self-checking bench for the overwrite flags and mailbox 0 mask
`timescale 1ns/1ns
module cuam_core_tb;
    logic clk_i;
    logic rst_i;
    logic [4:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0] avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    cuam_pkg::cuam_rx_t rx;
    cuam_pkg::cuam_filt_t filt;
    logic mb0_hit_o;
    cuam_pkg::cuam_store_t store_o;
    logic [15:0] rx_pending_o;
    logic [15:0] overwrite_o;
    logic irq_o;
    int err_total = 0;
    int compares = 0;
    integer seed = 32'h0000_b0a2;
    logic [15:0] expq[$];
    cuam_core dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx), .mb0_filt_i(filt),
        .mb0_hit_o(mb0_hit_o), .store_o(store_o), .rx_pending_o(rx_pending_o),
        .overwrite_o(overwrite_o), .irq_o(irq_o));
    cuam_bus_model p (.clk_i(clk_i), .rx_o(rx), .filt_o(filt));
    always #20 clk_i = ~clk_i;
    // ----
    // Checking and closing
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Reads complete at the edge where waitrequest is seen low
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            if (expq.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
            else chk(avs_readdata_o, {16'h0000, expq.pop_front()});
        end
    end
    // ----
    // Avalon master: hold until waitrequest low at a rising edge
    // ----
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= {16'h0000, d};
        if (!wr) expq.push_back(d);
        n = 0;
        // Sampled at the rising edge, before the slave's registers move
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        // A stuck slave counts once; the run still ends at the single verdict
        if (avs_waitrequest_o !== 1'b0) err_total++;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    function automatic logic exp_hit(input logic ri, input logic [28:0] rid, input logic fi,
            input logic [28:0] fid, input logic [15:0] lo, input logic [15:0] hi);
        logic [28:0] m;
        m = {hi[7:0], hi[15:13], hi[9:8], lo[7:0], lo[15:8]};
        return (ri == fi) && (((rid ^ fid) & ~m &
            (ri ? cuam_pkg::EXT_SCOPE : cuam_pkg::STD_SCOPE)) == 29'h0000_0000);
    endfunction
    // ----
    // Main sequence
    // ----
    initial begin
        logic [3:0] mb;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [28:0] fid;
        logic [28:0] rid;
        logic ri;
        clk_i = 1'b0;
        rst_i = 1'b1;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'hf;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, cuam_pkg::OFS_OVW, 16'h0000);
        bus(0, cuam_pkg::OFS_AML, 16'h0000);
        bus(1, cuam_pkg::OFS_AMH, 16'hffff);
        bus(0, cuam_pkg::OFS_AMH, 16'he3ff);
        bus(1, 5'h1c, 16'hffff);
        bus(0, 5'h1c, 16'h0000);
        // Two frames each into mailboxes 3 and 9, the second unread
        for (int i = 0; i < 4; i++) begin
            mb = i[1] ? 4'h9 : 4'h3;
            p.frame_end(mb);
            @(negedge clk_i);
            chk(store_o, {1'b1, mb});
            chk(rx_pending_o[mb], 1'b1);
            chk(overwrite_o[mb], i[0]);
        end
        chk(irq_o, 1'b0);
        bus(0, cuam_pkg::OFS_OVW, 16'h0802);
        bus(0, cuam_pkg::OFS_PND, 16'h0802);
        bus(1, cuam_pkg::OFS_OVW, 16'h0000);
        bus(0, cuam_pkg::OFS_OVW, 16'h0802);
        bus(1, cuam_pkg::OFS_OVW, 16'h0800);
        bus(0, cuam_pkg::OFS_OVW, 16'h0002);
        bus(1, cuam_pkg::OFS_PND, 16'h0800);
        bus(0, cuam_pkg::OFS_PND, 16'h0002);
        // Interrupt: masked, enabled, cleared by reading status
        bus(1, cuam_pkg::OFS_IMK, 16'h0001);
        @(negedge clk_i);
        chk(irq_o, 1'b1);
        bus(0, cuam_pkg::OFS_IST, 16'h0003);
        @(negedge clk_i);
        chk(irq_o, 1'b0);
        // Random masks; odd passes flip one id bit
        for (int i = 0; i < 12; i++) begin
            lo = 16'($random(seed));
            hi = 16'($random(seed)) & cuam_pkg::AMH_RW_MASK;
            bus(1, cuam_pkg::OFS_AML, lo);
            bus(1, cuam_pkg::OFS_AMH, hi);
            fid = 29'($random(seed));
            ri = i[1];
            rid = fid ^ (i[0] ? (29'h0000_0001 << ($unsigned($random(seed)) % 29)) : 29'h0);
            p.present(ri, rid, ri ^ (i == 11), fid);
            @(posedge clk_i);
            @(negedge clk_i);
            chk(mb0_hit_o, exp_hit(ri, rid, ri ^ (i == 11), fid, lo, hi));
        end
        chk(expq.size(), 0);
        report_and_stop();
    end
endmodule

//--- rtl/cuam_core.sv
// Unread-overwrite flags, mailbox 0 acceptance mask and Avalon-MM slave
//
// Functional notes
// - A mailbox's overwrite flag sets when a message lands while its pending flag is set.
// - Overwrite flags clear only when software writes 1 to their bit; zeros do nothing.
// - The overwrite register is 16 bits, reset 0, mailboxes 7..0 in bits 15..8, 15..8 in 7..0.
// - A new message always rewrites the mailbox, so earlier unread data is lost.
// - The acceptance mask only affects mailbox 0 matching; a 1 excludes that id bit.
// - Low mask bits 15..8 cover id 7..0 and bits 7..0 cover id 15..8, reset 0.
// - High mask bits 15..13 cover id 20..18, 9..8 id 17..16, 7..0 id 28..21, reset 0.
// - High mask bits 12..10 read 0 and software writes only 0 to them.
// - A mailbox's receive pending flag sets when reception into it ends.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module cuam_core #(
    parameter int NMBOX = cuam_pkg::NMBOX
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [cuam_pkg::AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Receive path
    input wire cuam_pkg::cuam_rx_t rx_i,
    input wire cuam_pkg::cuam_filt_t mb0_filt_i,
    output logic mb0_hit_o,
    output cuam_pkg::cuam_store_t store_o,
    output logic [NMBOX-1:0] rx_pending_o,
    output logic [NMBOX-1:0] overwrite_o,
    // Interrupt
    output logic irq_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Flag registers keep mailbox order; the bus sees byte-swapped words
    function automatic logic [15:0] swap16(input logic [15:0] x);
        swap16 = {x[7:0], x[15:8]};
    endfunction

    function automatic logic [cuam_pkg::IDW-1:0] id_mask(
        input logic [15:0] lo, input logic [15:0] hi);
        id_mask = {hi[7:0], hi[15:13], hi[9:8], lo[7:0], lo[15:8]};
    endfunction

    // ------------------------------------------------------------
    // Bus handshake: one wait state on every access
    // ------------------------------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic req, acc, wr_acc, rd_acc;
    logic [15:0] bmask, wd16;

    assign req = avs_read_i | avs_write_i;
    assign acc = req & ack_q;
    assign wr_acc = avs_write_i & ack_q;
    assign rd_acc = avs_read_i & ack_q;
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign bmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wd16 = avs_writedata_i[15:0] & bmask;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [NMBOX-1:0] ovw_q, ovw_d, pnd_q, pnd_d;
    logic [NMBOX-1:0] ovw_clr, pnd_clr, rx_hit_mb;
    logic [15:0] aml_q, aml_d, amh_q, amh_d;
    logic [cuam_pkg::IEVW-1:0] ist_q, ist_d, imk_q, imk_d, iev;
    logic wr_ovw, wr_pnd, wr_aml, wr_amh, wr_imk, rd_ist;

    assign wr_ovw = wr_acc && avs_address_i == cuam_pkg::OFS_OVW;
    assign wr_pnd = wr_acc && avs_address_i == cuam_pkg::OFS_PND;
    assign wr_aml = wr_acc && avs_address_i == cuam_pkg::OFS_AML;
    assign wr_amh = wr_acc && avs_address_i == cuam_pkg::OFS_AMH;
    assign wr_imk = wr_acc && avs_address_i == cuam_pkg::OFS_IMK;
    assign rd_ist = rd_acc && avs_address_i == cuam_pkg::OFS_IST;

    // Only bits written as 1 clear; zeros leave flags alone
    assign ovw_clr = wr_ovw ? swap16(wd16) : '0;
    assign pnd_clr = wr_pnd ? swap16(wd16) : '0;

    // Per-mailbox flag update; a set in the clearing cycle wins
    genvar g;
    generate
        for (g = 0; g < NMBOX; g++) begin : g_mb
            assign rx_hit_mb[g] = rx_i.done && rx_i.mbox == 4'(g);
            always_comb begin
                ovw_d[g] = (ovw_q[g] & ~ovw_clr[g]) | (rx_hit_mb[g] & pnd_q[g]);
                pnd_d[g] = (pnd_q[g] & ~pnd_clr[g]) | rx_hit_mb[g];
            end
        end
    endgenerate

    assign iev[cuam_pkg::IEV_OVW] = |(rx_hit_mb & pnd_q);
    assign iev[cuam_pkg::IEV_RX] = rx_i.done;

    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        aml_d = aml_q;
        amh_d = amh_q;
        imk_d = imk_q;
        ist_d = ist_q | iev;
        if (rd_ist) begin
            // Clear only what the read returned, so late events survive
            ist_d = (ist_q & ~rdata_q[cuam_pkg::IEVW-1:0]) | iev;
        end
        if (wr_aml) begin
            aml_d = (aml_q & ~bmask) | wd16;
        end
        if (wr_amh) begin
            amh_d = ((amh_q & ~bmask) | wd16) & cuam_pkg::AMH_RW_MASK;
        end
        if (wr_imk) begin
            imk_d = wd16[cuam_pkg::IEVW-1:0];
        end
        if (req && !ack_q) begin
            case (avs_address_i)
                cuam_pkg::OFS_OVW: rdata_d = {16'h0000, swap16(ovw_q)};
                cuam_pkg::OFS_AML: rdata_d = {16'h0000, aml_q};
                cuam_pkg::OFS_AMH: rdata_d = {16'h0000, amh_q};
                cuam_pkg::OFS_PND: rdata_d = {16'h0000, swap16(pnd_q)};
                cuam_pkg::OFS_IST: rdata_d = {30'h0000_0000, ist_q};
                cuam_pkg::OFS_IMK: rdata_d = {30'h0000_0000, imk_q};
                default: rdata_d = cuam_pkg::RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= cuam_pkg::RD_ZERO;
            ovw_q <= '0;
            pnd_q <= '0;
            aml_q <= cuam_pkg::RST_REG;
            amh_q <= cuam_pkg::RST_REG;
            ist_q <= '0;
            imk_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ovw_q <= ovw_d;
            pnd_q <= pnd_d;
            aml_q <= aml_d;
            amh_q <= amh_d;
            ist_q <= ist_d;
            imk_q <= imk_d;
        end
    end

    // ------------------------------------------------------------
    // Mailbox 0 acceptance and store strobe
    // ------------------------------------------------------------
    logic [cuam_pkg::IDW-1:0] scope, diff;
    logic hit_q, hit_d;
    cuam_pkg::cuam_store_t st_q, st_d;

    // Mask only steers mailbox 0; other mailboxes match elsewhere
    assign scope = rx_i.ide ? cuam_pkg::EXT_SCOPE : cuam_pkg::STD_SCOPE;
    assign diff = (rx_i.id ^ mb0_filt_i.id) & ~id_mask(aml_q, amh_q) & scope;

    always_comb begin
        hit_d = (rx_i.ide == mb0_filt_i.ide) && diff == '0;
        // Store is never held off by an unread message: old data is lost
        st_d.wr = rx_i.done;
        st_d.idx = rx_i.done ? rx_i.mbox : st_q.idx;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hit_q <= 1'b0;
            st_q <= '0;
        end else begin
            hit_q <= hit_d;
            st_q <= st_d;
        end
    end

    assign mb0_hit_o = hit_q;
    assign store_o = st_q;
    assign rx_pending_o = pnd_q;
    assign overwrite_o = ovw_q;
    assign irq_o = |(ist_q & imk_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ovw_set_hit: assert property (
        rx_i.done && pnd_q[rx_i.mbox] |=> ovw_q[$past(rx_i.mbox)])
        else $error("overwrite flag not set on overwrite");

    a_ovw_only_w1c: assert property (
        ((($past(ovw_q) & ~ovw_q) & ~$past(ovw_clr)) == '0))
        else $error("overwrite flag cleared without write of 1");

    a_ovw_no_spur: assert property (
        !rx_i.done |=> ((ovw_q & ~$past(ovw_q)) == '0))
        else $error("overwrite flag set without reception");

    a_ovw_read_map: assert property (
        rd_acc && avs_address_i == cuam_pkg::OFS_OVW && $stable(ovw_q)
        |-> avs_readdata_o[15:0] == swap16(ovw_q))
        else $error("overwrite register bit order wrong");

    a_store_always: assert property (
        rx_i.done |=> store_o.wr && store_o.idx == $past(rx_i.mbox))
        else $error("reception did not rewrite mailbox");

    a_std_match: assert property (
        !rx_i.ide && !mb0_filt_i.ide
        && ((rx_i.id ^ mb0_filt_i.id) & cuam_pkg::STD_SCOPE) == '0 |=> mb0_hit_o)
        else $error("standard frame equal in 28..18 not accepted");

    a_mask_exclude: assert property (
        rx_i.ide == mb0_filt_i.ide && rx_i.ide
        && (((rx_i.id ^ mb0_filt_i.id) & ~id_mask(aml_q, amh_q)) == '0) |=> mb0_hit_o)
        else $error("masked id difference still rejected");

    a_amh_resv: assert property (
        ack_q && avs_read_i && avs_address_i == cuam_pkg::OFS_AMH
        |-> avs_readdata_o[12:10] == 3'h0)
        else $error("reserved mask bits read nonzero");

    a_pnd_set: assert property (
        rx_i.done |=> pnd_q[$past(rx_i.mbox)])
        else $error("pending flag not set on reception end");

    a_one_wait: assert property (
        req && !ack_q |=> !avs_waitrequest_o ##1 !ack_q)
        else $error("bus answer not after one wait state");

    a_wait_first: assert property (
        req && !ack_q |-> avs_waitrequest_o)
        else $error("first cycle of an access not held off");

    a_rd_upper: assert property (
        rd_acc |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("upper read data half not zero");

    a_ovw_w1c_clr: assert property (
        wr_ovw && !rx_i.done
        |=> (ovw_q & $past(ovw_clr)) == '0)
        else $error("overwrite flag not cleared by write of 1");

    a_pnd_w1c_clr: assert property (
        wr_pnd && !rx_i.done
        |=> (pnd_q & $past(pnd_clr)) == '0)
        else $error("pending flag not cleared by write of 1");

    a_store_pulse: assert property (
        !rx_i.done |=> !store_o.wr)
        else $error("store strobe without reception");

    a_ide_differ: assert property (
        rx_i.ide != mb0_filt_i.ide |=> !mb0_hit_o)
        else $error("format mismatch accepted into mailbox 0");

    a_unmasked_miss: assert property (
        rx_i.ide == mb0_filt_i.ide && ((rx_i.id ^ mb0_filt_i.id) & ~id_mask(aml_q, amh_q)
        & (rx_i.ide ? cuam_pkg::EXT_SCOPE : cuam_pkg::STD_SCOPE)) != '0 |=> !mb0_hit_o)
        else $error("unmasked id difference accepted");

    a_aml_write: assert property (
        wr_aml && avs_byteenable_i[1:0] == 2'h3
        |=> aml_q == $past(avs_writedata_i[15:0]))
        else $error("low mask write not stored");

    a_amh_write: assert property (
        wr_amh && avs_byteenable_i[1:0] == 2'h3
        |=> amh_q == ($past(avs_writedata_i[15:0]) & cuam_pkg::AMH_RW_MASK))
        else $error("high mask write not stored");

    a_amh_resv_q: assert property (
        (amh_q & ~cuam_pkg::AMH_RW_MASK) == '0)
        else $error("reserved mask bits hold a one");

    a_ist_ovw_set: assert property (
        rx_i.done && pnd_q[rx_i.mbox] |=> ist_q[cuam_pkg::IEV_OVW])
        else $error("overwrite event not recorded in status");

    a_ist_sticky: assert property (
        ist_q[cuam_pkg::IEV_OVW] && !rd_ist
        |=> ist_q[cuam_pkg::IEV_OVW])
        else $error("status bit dropped without a read");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_overwrite: cover property (rx_i.done && pnd_q[rx_i.mbox] ##1 irq_o);
    c_w1c_clear: cover property (wr_ovw && ovw_q != '0 ##1 ovw_q == '0);
    c_mask_hit: cover property (hit_d && (rx_i.id != mb0_filt_i.id));
    c_ist_read: cover property (rd_ist && ist_q != '0);
    c_set_wins: cover property (rx_i.done && pnd_q[rx_i.mbox] && ovw_clr[rx_i.mbox]);
endmodule

//--- shared/cuam_pkg.sv
// Register map, field layouts and carriers for the unread/accept-mask block
package cuam_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NMBOX = 16;
    localparam int IDW = 29;
    localparam int REGW = 16;
    localparam int AW = 5;
    // ------------------------------------------------------------
    // Byte offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_OVW = 5'h00;
    localparam logic [AW-1:0] OFS_AML = 5'h04;
    localparam logic [AW-1:0] OFS_AMH = 5'h08;
    localparam logic [AW-1:0] OFS_PND = 5'h0c;
    localparam logic [AW-1:0] OFS_IST = 5'h10;
    localparam logic [AW-1:0] OFS_IMK = 5'h14;
    // ------------------------------------------------------------
    // Reset values and field masks
    // ------------------------------------------------------------
    localparam logic [REGW-1:0] RST_REG = 16'h0000;
    localparam logic [REGW-1:0] AMH_RW_MASK = 16'he3ff;
    localparam logic [IDW-1:0] STD_SCOPE = 29'h1ffc_0000;
    localparam logic [IDW-1:0] EXT_SCOPE = 29'h1fff_ffff;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // Interrupt status bit positions
    localparam int IEV_OVW = 0;
    localparam int IEV_RX = 1;
    localparam int IEVW = 2;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic done;
        logic [3:0] mbox;
        logic ide;
        logic [IDW-1:0] id;
    } cuam_rx_t;
    typedef struct packed {
        logic ide;
        logic [IDW-1:0] id;
    } cuam_filt_t;
    typedef struct packed {
        logic wr;
        logic [3:0] idx;
    } cuam_store_t;
endpackage
